// >>> common/bbf_pkg.sv
// Purpose: shared constants for the branch, bit and flag execution unit
// Assumes: classic Wishbone slave, 32-bit data, byte addresses
// Notes: opcodes, register offsets and field positions live here only
package bbf_pkg;

  // ***************************************************************
  // sizes and defaults
  // ***************************************************************
  localparam int BBF_PC_W_DEF = 9;
  localparam int BBF_IO_N_DEF = 16;
  localparam int BBF_OFS_W = 7;
  localparam int BBF_ADR_W = 8;

  // ***************************************************************
  // register byte offsets
  // ***************************************************************
  localparam logic [7:0] BBF_ADR_CMD = 8'h00;
  localparam logic [7:0] BBF_ADR_FLAGS = 8'h04;
  localparam logic [7:0] BBF_ADR_PC = 8'h08;
  localparam logic [7:0] BBF_ADR_WORK = 8'h0C;
  localparam logic [7:0] BBF_ADR_STAT = 8'h10;
  localparam logic [1:0] BBF_IO_PAGE = 2'h1;

  // ***************************************************************
  // command word fields and status register cycle field
  // ***************************************************************
  localparam int BBF_CMD_OP_LSB = 0;
  localparam int BBF_CMD_BIT_LSB = 5;
  localparam int BBF_CMD_IO_LSB = 8;
  localparam int BBF_CMD_OFS_LSB = 12;
  localparam int BBF_CMD_W = 19;
  localparam int BBF_STAT_CYC_LSB = 8;

  // ***************************************************************
  // status register bit positions
  // ***************************************************************
  localparam int BBF_F_C = 0;
  localparam int BBF_F_Z = 1;
  localparam int BBF_F_N = 2;
  localparam int BBF_F_V = 3;
  localparam int BBF_F_S = 4;
  localparam int BBF_F_H = 5;
  localparam int BBF_F_T = 6;
  localparam int BBF_F_I = 7;
  localparam logic [7:0] BBF_FLAGS_RST = 8'h00;

  // ***************************************************************
  // opcodes
  // ***************************************************************
  localparam logic [4:0] OP_NOP = 5'h00;
  localparam logic [4:0] OP_BRANCH_EQUAL = 5'h01;
  localparam logic [4:0] OP_BRANCH_NOT_EQUAL = 5'h02;
  localparam logic [4:0] OP_BRANCH_CARRY_SET = 5'h03;
  localparam logic [4:0] OP_BRANCH_CARRY_CLEAR = 5'h04;
  localparam logic [4:0] OP_BRANCH_SAME_OR_HIGHER = 5'h05;
  localparam logic [4:0] OP_BRANCH_LOWER = 5'h06;
  localparam logic [4:0] OP_BRANCH_MINUS = 5'h07;
  localparam logic [4:0] OP_BRANCH_PLUS = 5'h08;
  localparam logic [4:0] OP_BRANCH_SIGNED_GE = 5'h09;
  localparam logic [4:0] OP_BRANCH_SIGNED_LT = 5'h0A;
  localparam logic [4:0] OP_BRANCH_HALF_CARRY_SET = 5'h0B;
  localparam logic [4:0] OP_BRANCH_HALF_CARRY_CLEAR = 5'h0C;
  localparam logic [4:0] OP_BRANCH_TRANSFER_SET = 5'h0D;
  localparam logic [4:0] OP_BRANCH_TRANSFER_FLAG = 5'h0E;
  localparam logic [4:0] OP_BRANCH_OVERFLOW_SET = 5'h0F;
  localparam logic [4:0] OP_BRANCH_OVERFLOW_CLEAR = 5'h10;
  localparam logic [4:0] OP_BRANCH_IRQ_ENABLED = 5'h11;
  localparam logic [4:0] OP_BRANCH_IRQ_DISABLED = 5'h12;
  localparam logic [4:0] OP_BRANCH_FLAG_INDEX_SET = 5'h13;
  localparam logic [4:0] OP_BRANCH_FLAG_INDEX_CLEAR = 5'h14;
  localparam logic [4:0] OP_IO_BIT_FORCE_ONE = 5'h15;
  localparam logic [4:0] OP_IO_BIT_FORCE_ZERO = 5'h16;
  localparam logic [4:0] OP_SHIFT_LEFT_LOGICAL = 5'h17;
  localparam logic [4:0] OP_SHIFT_RIGHT_LOGICAL = 5'h18;
  localparam logic [4:0] OP_ROTATE_RIGHT_THRU_CARRY = 5'h19;
  localparam logic [4:0] OP_ARITH_SHIFT_RIGHT = 5'h1A;
  localparam logic [4:0] OP_BIT_TO_TRANSFER_FLAG = 5'h1B;
  localparam logic [4:0] OP_TRANSFER_FLAG_TO_BIT = 5'h1C;
  localparam logic [4:0] OP_FLAG_FORCE_ONE = 5'h1D;
  localparam logic [4:0] OP_FLAG_FORCE_ZERO = 5'h1E;
  localparam logic [4:0] OP_SWAP_NIBBLES = 5'h1F;

  // ***************************************************************
  // sequencer states
  // ***************************************************************
  typedef enum logic [1:0] {BBF_IDLE, BBF_EXEC, BBF_SECOND} bbf_fsm_e;

endpackage

// >>> core/bbf_exec_core.sv
// Purpose: branch, single-bit, shift and flag execution unit with Wishbone registers
// Assumes: classic Wishbone on sys_clk, one request at a time
// Notes: a command write starts one instruction; writes while busy are dropped
//
// Functional notes
// - equal/not-equal branch on zero flag
// - carry branches: set, lower, clear, same-or-higher
// - minus/plus branches on negative flag
// - signed ge taken when N xor V is 0
// - signed lt taken when N xor V is 1
// - half-carry branches on H set or clear
// - transfer-flag branches on T set or clear
// - overflow branches on V set or clear
// - interrupt branches on I, no flag change
// - io bit force one/zero, two cycles
// - logical shifts insert zero, update ZCNV
// - rotate right through old carry, update ZCNV
// - arithmetic right shift keeps bit 7
// - bit store copies register bit into T
// - bit load writes T into register bit
// - set/clear any single status flag
// - clear overflow touches only V
// - set/clear signed flag in one cycle
// - generic branch tests flag by index
`timescale 1ns/1ns
module bbf_exec_core #(
  parameter int PC_W = bbf_pkg::BBF_PC_W_DEF,
  parameter int IO_N = bbf_pkg::BBF_IO_N_DEF
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [bbf_pkg::BBF_ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // execution status
  output logic busy
);
  import bbf_pkg::*;

  localparam int IOA_W = $clog2(IO_N);
  localparam logic [PC_W-1:0] PC_ONE = PC_W'(1);

  // ***************************************************************
  // parameter checks
  // ***************************************************************
  // the sign-extended offset must fit inside the pc
  if (PC_W < BBF_OFS_W + 1 || PC_W > 16) begin : g_pc_chk
    $error("PC_W must be 8 to 16");
  end
  // io index is a whole number of address bits
  if (IO_N < 2 || IO_N > 16 || (IO_N & (IO_N - 1)) != 0) begin : g_io_chk
    $error("IO_N must be a power of two from 2 to 16");
  end
  // command word must hold the io index below the offset field
  if (BBF_CMD_OFS_LSB + BBF_OFS_W != BBF_CMD_W ||
      BBF_CMD_IO_LSB + IOA_W > BBF_CMD_OFS_LSB) begin : g_cmd_chk
    $error("command word layout does not fit IO_N");
  end

  // ***************************************************************
  // state
  // ***************************************************************
  typedef struct packed {
    bbf_fsm_e state;
    logic busy;
    logic ack;
    logic [31:0] rdata;
    logic [PC_W-1:0] pc;
    logic [7:0] flags;
    logic [7:0] work;
    logic [IO_N-1:0][7:0] io;
    logic [BBF_CMD_W-1:0] cmd;
    logic [7:0] ioLatch;
    logic [1:0] lastCycles;
  } bbf_state_s;

  bbf_state_s r;
  bbf_state_s next_r;

  // ***************************************************************
  // helper functions
  // ***************************************************************
  // byte-lane merge of a bus write into an old word
  function automatic logic [31:0] mergeBytes(input logic [31:0] old, input logic [31:0] dat,
                                             input logic [3:0] sel);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        res[8*i +: 8] = dat[8*i +: 8];
      end
    end
    return res;
  endfunction

  // true for every conditional branch opcode
  function automatic logic isBranch(input logic [4:0] op);
    return (op >= OP_BRANCH_EQUAL) && (op <= OP_BRANCH_FLAG_INDEX_CLEAR);
  endfunction

  // true for the four shift and rotate forms that share one flag update
  function automatic logic isShift(input logic [4:0] op);
    return (op >= OP_SHIFT_LEFT_LOGICAL) && (op <= OP_ARITH_SHIFT_RIGHT);
  endfunction

  // branch condition from the status flags
  function automatic logic branchTaken(input logic [4:0] op, input logic [2:0] idx,
                                       input logic [7:0] f);
    logic t;
    t = 1'b0;
    case (op)
      OP_BRANCH_EQUAL: t = f[BBF_F_Z];
      OP_BRANCH_NOT_EQUAL: t = ~f[BBF_F_Z];
      OP_BRANCH_CARRY_SET: t = f[BBF_F_C];
      OP_BRANCH_LOWER: t = f[BBF_F_C];
      OP_BRANCH_CARRY_CLEAR: t = ~f[BBF_F_C];
      OP_BRANCH_SAME_OR_HIGHER: t = ~f[BBF_F_C];
      OP_BRANCH_MINUS: t = f[BBF_F_N];
      OP_BRANCH_PLUS: t = ~f[BBF_F_N];
      OP_BRANCH_SIGNED_GE: t = ~(f[BBF_F_N] ^ f[BBF_F_V]);
      OP_BRANCH_SIGNED_LT: t = f[BBF_F_N] ^ f[BBF_F_V];
      OP_BRANCH_HALF_CARRY_SET: t = f[BBF_F_H];
      OP_BRANCH_HALF_CARRY_CLEAR: t = ~f[BBF_F_H];
      OP_BRANCH_TRANSFER_SET: t = f[BBF_F_T];
      OP_BRANCH_TRANSFER_FLAG: t = ~f[BBF_F_T];
      OP_BRANCH_OVERFLOW_SET: t = f[BBF_F_V];
      OP_BRANCH_OVERFLOW_CLEAR: t = ~f[BBF_F_V];
      OP_BRANCH_IRQ_ENABLED: t = f[BBF_F_I];
      OP_BRANCH_IRQ_DISABLED: t = ~f[BBF_F_I];
      OP_BRANCH_FLAG_INDEX_SET: t = f[idx];
      OP_BRANCH_FLAG_INDEX_CLEAR: t = ~f[idx];
      default: t = 1'b0;
    endcase
    return t;
  endfunction

  // ***************************************************************
  // next-state logic
  // ***************************************************************
  // bus decode and fields of the held command
  logic access;
  logic [4:0] op;
  logic [2:0] bitIdx;
  logic [IOA_W-1:0] ioIdx;
  logic [PC_W-1:0] ofsExt;
  logic [7:0] res;
  logic newC;
  logic ioHit;
  logic [IOA_W-1:0] busIo;
  logic [31:0] cmdMerged;
  logic [31:0] pcMerged;

  // writes are taken only while idle: a register changed under a running
  // instruction would mix old and new operands, so such writes are acked
  // and dropped; software polls busy before the next command
  // bus decode, instruction sequencing and flag updates
  always_comb begin
    next_r = r;
    next_r.ack = 1'b0;
    access = wb_cyc_i & wb_stb_i & ~r.ack;
    op = r.cmd[BBF_CMD_OP_LSB +: 5];
    bitIdx = r.cmd[BBF_CMD_BIT_LSB +: 3];
    ioIdx = r.cmd[BBF_CMD_IO_LSB +: IOA_W];
    ofsExt = {{(PC_W - BBF_OFS_W){r.cmd[BBF_CMD_OFS_LSB + BBF_OFS_W - 1]}},
              r.cmd[BBF_CMD_OFS_LSB +: BBF_OFS_W]};
    res = r.work;
    newC = r.flags[BBF_F_C];
    ioHit = (wb_adr_i[7:6] == BBF_IO_PAGE) && (32'(wb_adr_i[5:2]) < IO_N);
    busIo = wb_adr_i[2 +: IOA_W];
    // word-wide lane merges for the command and pc writes
    cmdMerged = mergeBytes(32'(r.cmd), wb_dat_i, wb_sel_i);
    pcMerged = mergeBytes(32'(r.pc), wb_dat_i, wb_sel_i);

    // register access: answer one cycle after the request is taken
    if (access) begin
      next_r.ack = 1'b1;
      next_r.rdata = 32'h0000_0000;
      if (ioHit) begin
        next_r.rdata = {24'h00_0000, r.io[busIo]};
      end else begin
        case (wb_adr_i)
          BBF_ADR_CMD: next_r.rdata = 32'(r.cmd);
          BBF_ADR_FLAGS: next_r.rdata = {24'h00_0000, r.flags};
          BBF_ADR_PC: next_r.rdata = 32'(r.pc);
          BBF_ADR_WORK: next_r.rdata = {24'h00_0000, r.work};
          BBF_ADR_STAT: begin
            next_r.rdata[BBF_STAT_CYC_LSB +: 2] = r.lastCycles;
            next_r.rdata[0] = r.busy;
          end
          default: next_r.rdata = 32'h0000_0000;
        endcase
      end
      if (wb_we_i && r.state == BBF_IDLE) begin
        if (ioHit) begin
          if (wb_sel_i[0]) begin
            next_r.io[busIo] = wb_dat_i[7:0];
          end
        end else begin
          case (wb_adr_i)
            BBF_ADR_CMD: begin
              next_r.cmd = cmdMerged[BBF_CMD_W-1:0];
              next_r.state = BBF_EXEC;
              next_r.busy = 1'b1;
            end
            BBF_ADR_FLAGS: begin
              if (wb_sel_i[0]) begin
                next_r.flags = wb_dat_i[7:0];
              end
            end
            BBF_ADR_PC: begin
              next_r.pc = pcMerged[PC_W-1:0];
            end
            BBF_ADR_WORK: begin
              if (wb_sel_i[0]) begin
                next_r.work = wb_dat_i[7:0];
              end
            end
            default: next_r.pc = r.pc;
          endcase
        end
      end
    end

    // instruction execution
    // idle waits for a command; exec runs one-cycle work and decides
    case (r.state)
      BBF_IDLE: begin
        next_r.ioLatch = r.ioLatch;
      end
      BBF_EXEC: begin
        next_r.state = BBF_IDLE;
        next_r.busy = 1'b0;
        next_r.lastCycles = 2'h1;
        next_r.pc = r.pc + PC_ONE;
        if (isBranch(op)) begin
          if (branchTaken(op, bitIdx, r.flags)) begin
            next_r.state = BBF_SECOND;
            next_r.busy = 1'b1;
            next_r.pc = r.pc;
          end
        end else begin
          case (op)
            OP_IO_BIT_FORCE_ONE, OP_IO_BIT_FORCE_ZERO: begin
              // read the io word now, write it back in the second cycle
              next_r.ioLatch = r.io[ioIdx];
              next_r.state = BBF_SECOND;
              next_r.busy = 1'b1;
              next_r.pc = r.pc;
            end
            OP_SHIFT_LEFT_LOGICAL: begin
              res = {r.work[6:0], 1'b0};
              newC = r.work[7];
            end
            OP_SHIFT_RIGHT_LOGICAL: begin
              res = {1'b0, r.work[7:1]};
              newC = r.work[0];
            end
            OP_ROTATE_RIGHT_THRU_CARRY: begin
              res = {r.flags[BBF_F_C], r.work[7:1]};
              newC = r.work[0];
            end
            OP_ARITH_SHIFT_RIGHT: begin
              res = {r.work[7], r.work[7:1]};
              newC = r.work[0];
            end
            OP_BIT_TO_TRANSFER_FLAG: begin
              next_r.flags[BBF_F_T] = r.work[bitIdx];
            end
            OP_TRANSFER_FLAG_TO_BIT: begin
              next_r.work[bitIdx] = r.flags[BBF_F_T];
            end
            OP_FLAG_FORCE_ONE: begin
              next_r.flags[bitIdx] = 1'b1;
            end
            OP_FLAG_FORCE_ZERO: begin
              next_r.flags[bitIdx] = 1'b0;
            end
            OP_SWAP_NIBBLES: begin
              next_r.work = {r.work[3:0], r.work[7:4]};
            end
            default: next_r.work = r.work;
          endcase
          // shared flag update for the four shift forms; S is left alone
          if (isShift(op)) begin
            next_r.work = res;
            next_r.flags[BBF_F_Z] = (res == 8'h00);
            next_r.flags[BBF_F_C] = newC;
            next_r.flags[BBF_F_N] = res[7];
            next_r.flags[BBF_F_V] = res[7] ^ newC;
          end
        end
      end
      // second cycle: taken branch target, or io write-back
      BBF_SECOND: begin
        next_r.state = BBF_IDLE;
        next_r.busy = 1'b0;
        next_r.lastCycles = 2'h2;
        if (isBranch(op)) begin
          next_r.pc = r.pc + ofsExt + PC_ONE;
        end else begin
          next_r.pc = r.pc + PC_ONE;
          next_r.io[ioIdx] = r.ioLatch;
          next_r.io[ioIdx][bitIdx] = (op == OP_IO_BIT_FORCE_ONE);
        end
      end
      default: begin
        next_r.state = BBF_IDLE;
        next_r.busy = 1'b0;
      end
    endcase
  end

  // ***************************************************************
  // state register
  // ***************************************************************
  // async clear to the reset pattern; only constants here
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      r <= '0;
      r.state <= BBF_IDLE;
      r.flags <= BBF_FLAGS_RST;
    end else begin
      r <= next_r;
    end
  end

  // ***************************************************************
  // outputs
  // ***************************************************************
  // outputs straight from the state flops
  assign wb_ack_o = r.ack;
  assign wb_dat_o = r.rdata;
  assign busy = r.busy;

endmodule

// >>> tb/bbf_exec_core_sva.sv
// Purpose: bus and sequencing checks on the execution unit ports
// Assumes: classic Wishbone, one clock, async active-low reset
// Notes: bound from the bench top file
`timescale 1ns/1ns
module bbf_exec_core_sva (
  // clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [bbf_pkg::BBF_ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // status
  input wire logic busy
);
  import bbf_pkg::*;
  logic cmdSeen;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!arst_n);

  // ***************************************************************
  // helper logic and sequences
  // ***************************************************************
  // remembers a command write taken at the last edge
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) cmdSeen <= 1'b0;
    else cmdSeen <= wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_adr_i == BBF_ADR_CMD;
  end
  sequence take_s;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence cmd_s;
    take_s ##0 (wb_we_i && wb_adr_i == BBF_ADR_CMD && !busy);
  endsequence
  sequence rd_s;
    take_s ##0 !wb_we_i;
  endsequence

  // ***************************************************************
  // assertions
  // ***************************************************************
  ack_after_take_a: assert property (take_s |=> wb_ack_o)
    else $error("no ack one cycle after request");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  busy_start_a: assert property (cmd_s |=> busy)
    else $error("command did not start");
  busy_len_a: assert property ($rose(busy) |-> ##[1:2] !busy)
    else $error("instruction longer than two cycles");
  busy_cause_a: assert property ($rose(busy) |-> cmdSeen)
    else $error("busy without command");
  flags_read_a: assert property (rd_s ##0 wb_adr_i == BBF_ADR_FLAGS
    |=> wb_dat_o[31:8] == 24'h0)
    else $error("flag read upper bits set");
  stat_read_a: assert property (rd_s ##0 wb_adr_i == BBF_ADR_STAT
    |=> wb_dat_o[31:10] == 22'h0 && wb_dat_o[9:8] != 2'h3)
    else $error("bad status read");
  unmapped_read_a: assert property (rd_s ##0 wb_adr_i inside {[8'h14:8'h3F]} |=> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  rdata_hold_a: assert property ($fell(wb_ack_o) |-> $stable(wb_dat_o))
    else $error("read data not held");
endmodule

// >>> tb/bbf_exec_core_tb.sv
// Purpose: directed bench for the branch, bit and flag unit
// Assumes: register map and opcodes of bbf_pkg, PC_W 9
// Notes: all traffic through Wishbone read and write tasks
`timescale 1ns/1ns
module bbf_exec_core_tb;
  import bbf_pkg::*;
  logic sysClk = 1'b0;
  logic arstN = 1'b0;
  logic wbCyc = 1'b0;
  logic wbStb = 1'b0;
  logic wbWe = 1'b0;
  logic [7:0] wbAdr = 8'h00;
  logic [3:0] wbSel = 4'h0;
  logic [31:0] wbDatI = 32'h0;
  logic [31:0] wbDatO;
  logic wbAck;
  logic busy;
  int failCount = 0;
  int cmpCount = 0;
  logic [7:0] pats [4] = '{8'h00, 8'hFF, 8'h5A, 8'hA5};
  logic [7:0] vals [3] = '{8'h81, 8'h01, 8'h40};

  // ***************************************************************
  // device and clock
  // ***************************************************************
  bbf_exec_core #(.PC_W(9), .IO_N(16)) i_bbf_exec_core (.sys_clk(sysClk), .arst_n(arstN),
    .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel),
    .wb_dat_i(wbDatI), .wb_dat_o(wbDatO), .wb_ack_o(wbAck), .busy(busy));
  // free running clock
  always #10 sysClk = ~sysClk;

  // ***************************************************************
  // bus tasks
  // ***************************************************************
  // one classic cycle, held until ack
  task automatic wbAcc(input logic we, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q);
    int n;
    n = 0;
    @(posedge sysClk);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbAdr <= a;
    wbSel <= 4'hF;
    wbDatI <= d;
    do begin
      @(posedge sysClk);
      n++;
    end while (wbAck !== 1'b1 && n < 50);
    if (n >= 50) begin
      failCount++;
      $display("ERROR %0t no ack", $time);
    end
    q = wbDatO;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    wbWe <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wbAcc(1'b1, a, d, q);
  endtask
  task automatic rdChk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    wbAcc(1'b0, a, 32'h0, q);
    cmpCount++;
    if (q !== e) begin
      failCount++;
      $display("ERROR %0t read %h got %h exp %h", $time, a, q, e);
    end
  endtask
  // start an instruction and wait for it to finish
  task automatic exec(input logic [31:0] c);
    int n;
    n = 0;
    wr(BBF_ADR_CMD, c);
    while (busy !== 1'b0 && n < 10) begin
      @(posedge sysClk);
      n++;
    end
    if (n >= 10) begin
      failCount++;
      $display("ERROR %0t busy stuck", $time);
    end
  endtask
  // own model of the branch condition
  function automatic logic taken(input logic [4:0] op, input logic [2:0] i, input logic [7:0] f);
    logic b;
    case (op)
      5'h01, 5'h02: b = f[BBF_F_Z];
      5'h03, 5'h04, 5'h05, 5'h06: b = f[BBF_F_C];
      5'h07, 5'h08: b = f[BBF_F_N];
      5'h09, 5'h0A: b = f[BBF_F_N] ^ f[BBF_F_V];
      5'h0B, 5'h0C: b = f[BBF_F_H];
      5'h0D, 5'h0E: b = f[BBF_F_T];
      5'h0F, 5'h10: b = f[BBF_F_V];
      5'h11, 5'h12: b = f[BBF_F_I];
      default: b = f[i];
    endcase
    return (op inside {1, 3, 6, 7, 10, 11, 13, 15, 17, 19}) ? b : !b;
  endfunction
  task automatic stopTest;
    if (failCount == 0 && cmpCount > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // ***************************************************************
  // tests
  // ***************************************************************
  // watchdog against a hang
  initial begin
    repeat (20000) @(posedge sysClk);
    failCount++;
    stopTest();
  end
  // main sequence
  initial begin
    logic [7:0] f;
    logic [7:0] w;
    logic [7:0] r;
    logic [6:0] k;
    logic [4:0] op;
    logic [2:0] idx;
    logic [8:0] pcx;
    logic c;
    logic tk;
    repeat (12) @(posedge sysClk);
    arstN <= 1'b1;
    rdChk(BBF_ADR_FLAGS, 32'h0);
    rdChk(BBF_ADR_PC, 32'h0);
    rdChk(BBF_ADR_WORK, 32'h0);
    rdChk(8'h20, 32'h0);
    wr(BBF_ADR_STAT, 32'hFFFFFFFF);
    rdChk(BBF_ADR_STAT, 32'h0);
    // every branch opcode against four flag patterns
    for (int p = 0; p < 4; p++) begin
      for (int o = 1; o <= 20; o++) begin
        f = pats[p];
        op = 5'(o);
        k = p[0] ? 7'h7D : 7'h3C;
        idx = 3'(p * 3 + o);
        tk = taken(op, idx, f);
        pcx = tk ? 9'h100 + {{2{k[6]}}, k} + 9'h1 : 9'h101;
        wr(BBF_ADR_FLAGS, {24'h0, f});
        wr(BBF_ADR_PC, 32'h100);
        exec({13'h0, k, 4'h0, idx, op});
        rdChk(BBF_ADR_PC, {23'h0, pcx});
        rdChk(BBF_ADR_FLAGS, {24'h0, f});
        rdChk(BBF_ADR_STAT, tk ? 32'h200 : 32'h100);
      end
    end
    // io bit force one and zero
    wr(BBF_ADR_FLAGS, 32'h5A);
    wr(8'h4C, 32'hA5);
    exec({13'h0, 7'h0, 4'h3, 3'h1, OP_IO_BIT_FORCE_ONE});
    rdChk(8'h4C, 32'hA7);
    exec({13'h0, 7'h0, 4'h3, 3'h7, OP_IO_BIT_FORCE_ZERO});
    rdChk(8'h4C, 32'h27);
    rdChk(BBF_ADR_STAT, 32'h200);
    rdChk(8'h48, 32'h0);
    rdChk(BBF_ADR_FLAGS, 32'h5A);
    // shifts and rotate over values and carry in
    for (int s = 0; s < 24; s++) begin
      op = 5'(5'h17 + s % 4);
      w = vals[s / 8];
      f = 8'h50 | 8'((s / 4) % 2);
      case (op)
        5'h17: r = {w[6:0], 1'b0};
        5'h18: r = {1'b0, w[7:1]};
        5'h19: r = {f[0], w[7:1]};
        default: r = {w[7], w[7:1]};
      endcase
      c = (op == 5'h17) ? w[7] : w[0];
      wr(BBF_ADR_FLAGS, {24'h0, f});
      wr(BBF_ADR_WORK, {24'h0, w});
      exec({27'h0, op});
      rdChk(BBF_ADR_WORK, {24'h0, r});
      rdChk(BBF_ADR_FLAGS, {24'h0, f[7:4], r[7] ^ c, r[7], r == 8'h0, c});
    end
    // bit store and bit load through the transfer flag
    wr(BBF_ADR_WORK, 32'h10);
    wr(BBF_ADR_FLAGS, 32'hBF);
    exec({24'h0, 3'h4, OP_BIT_TO_TRANSFER_FLAG});
    rdChk(BBF_ADR_FLAGS, 32'hFF);
    exec({24'h0, 3'h3, OP_BIT_TO_TRANSFER_FLAG});
    rdChk(BBF_ADR_FLAGS, 32'hBF);
    exec({24'h0, 3'h4, OP_TRANSFER_FLAG_TO_BIT});
    rdChk(BBF_ADR_WORK, 32'h0);
    wr(BBF_ADR_FLAGS, 32'h40);
    exec({24'h0, 3'h7, OP_TRANSFER_FLAG_TO_BIT});
    rdChk(BBF_ADR_WORK, 32'h80);
    rdChk(BBF_ADR_FLAGS, 32'h40);
    // every single flag forced one and zero
    for (int i = 0; i < 8; i++) begin
      wr(BBF_ADR_FLAGS, 32'h0);
      exec({24'h0, 3'(i), OP_FLAG_FORCE_ONE});
      rdChk(BBF_ADR_FLAGS, 32'h1 << i);
      wr(BBF_ADR_FLAGS, 32'hFF);
      exec({24'h0, 3'(i), OP_FLAG_FORCE_ZERO});
      rdChk(BBF_ADR_FLAGS, 32'hFF & ~(32'h1 << i));
      rdChk(BBF_ADR_STAT, 32'h100);
    end
    // nibble swap on the work register, then a plain no-operation
    wr(BBF_ADR_FLAGS, 32'h0);
    wr(BBF_ADR_WORK, 32'h3C);
    wr(BBF_ADR_PC, 32'h1FF);
    exec({27'h0, OP_SWAP_NIBBLES});
    rdChk(BBF_ADR_WORK, 32'hC3);
    rdChk(BBF_ADR_PC, 32'h0);
    exec({27'h0, OP_NOP});
    rdChk(BBF_ADR_PC, 32'h1);
    rdChk(BBF_ADR_WORK, 32'hC3);
    rdChk(BBF_ADR_FLAGS, 32'h0);
    // reset while idle clears the dirty state
    arstN <= 1'b0;
    repeat (2) @(posedge sysClk);
    arstN <= 1'b1;
    rdChk(BBF_ADR_WORK, 32'h0);
    rdChk(BBF_ADR_PC, 32'h0);
    rdChk(BBF_ADR_STAT, 32'h0);
    rdChk(8'h4C, 32'h0);
    stopTest();
  end
endmodule

bind bbf_exec_core bbf_exec_core_sva i_bbf_exec_core_sva (.sys_clk, .arst_n, .wb_cyc_i,
  .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .busy);
